// *** hw/hwm_regs.svh ***
`ifndef HWM_REGS_SVH
`define HWM_REGS_SVH
// Index map of the register page
`define HWM_IDX_CFG   7'h40
`define HWM_IDX_ST1   7'h41
`define HWM_IDX_ST2   7'h42
`define HWM_IDX_MSK1  7'h43
`define HWM_IDX_MSK2  7'h44
`define HWM_IDX_ICLR  7'h46
`define HWM_IDX_FDIV  7'h47
`define HWM_IDX_DEVID 7'h49
`define HWM_IDX_PINC  7'h4b
`define HWM_IDX_ALIAS 7'h60
`define HWM_IDX_TOP   7'h7f
// Reset values and the valid status bit mask
`define HWM_CFG_RST   8'h01
`define HWM_PINC_RST  8'h44
`define HWM_FDIV_RST  4'h5
`define HWM_ST_VALID  16'h17fd
// Arbitrary identification value
`define HWM_DEV_ID    7'h2a
// Configuration and clear bits
`define HWM_CFG_START 0
`define HWM_CFG_IRQEN 1
`define HWM_CFG_HALT  3
`define HWM_CFG_DFLT  7
`define HWM_ICLR_BIT  7
// Value RAM offsets
`define HWM_R_VCORE   5'h00
`define HWM_R_V33     5'h02
`define HWM_R_V5      5'h03
`define HWM_R_V12     5'h04
`define HWM_R_VN12    5'h05
`define HWM_R_VN5     5'h06
`define HWM_R_TEMP1   5'h07
`define HWM_R_FIRST_TACH    5'h08
`define HWM_R_SECOND_TACH    5'h09
`define HWM_R_VC_HI   5'h0b
`define HWM_R_VC_LO   5'h0c
`define HWM_R_V33_HI  5'h0f
`define HWM_R_V5_HI   5'h11
`define HWM_R_V12_HI  5'h13
`define HWM_R_VN12_HI 5'h15
`define HWM_R_VN5_HI  5'h17
`define HWM_R_T1_HI   5'h19
`define HWM_R_F1_LIM  5'h1b
`define HWM_R_F2_LIM  5'h1c
// Status bit positions, second register at 8 and up
`define HWM_SB_VCORE  4'd0
`define HWM_SB_V33    4'd2
`define HWM_SB_V5     4'd3
`define HWM_SB_T1     4'd4
`define HWM_SB_T2     5
`define HWM_SB_FIRST_TACH   4'd6
`define HWM_SB_SECOND_TACH   4'd7
`define HWM_SB_V12    4'd8
`define HWM_SB_VN12   4'd9
`define HWM_SB_VN5    4'd10
`define HWM_SB_INTR   12
// Core limit margin, 0.2 V in reading steps
`define HWM_VC_MARGIN 8'h0d
`endif

// *** hw/hwm_pkg.sv ***
package hwm_pkg;
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } hwm_host_s;
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] value;
  } hwm_conv_s;
  typedef struct packed {
    logic       vld;
    logic       has_lo;
    logic       sgn;
    logic [4:0] hi;
    logic [3:0] sbit;
  } hwm_lim_s;
endpackage

// *** hw/hwm_regbank.sv ***
`timescale 1ns/1ps
`include "hwm_regs.svh"

module hwm_regbank
  import hwm_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      sys_rst,
  input  wire hwm_host_s host_req,
  output logic [7:0]     host_rdata,
  input  wire hwm_conv_s conv,
  input  wire logic      temp_two_over,
  input  wire logic      intrusion_pin,
  input  wire logic [4:0] voltage_ident_straps,
  output logic           mgmt_interrupt_out,
  output logic           monitor_run,
  output logic [1:0]     adc_clk_sel,
  output logic           first_tach_divisor_lo,
  output logic           first_tach_divisor_hi,
  output logic           second_tach_divisor_lo,
  output logic           second_tach_divisor_hi
);

  // ****************************************
  // Limit lookup
  // ****************************************
  function automatic hwm_lim_s lim_map(input logic [4:0] ch);
    hwm_lim_s m;
    m = '0;
    m.vld = 1'b1;
    m.has_lo = 1'b1;
    unique case (ch)
      `HWM_R_VCORE: begin m.hi = `HWM_R_VC_HI;   m.sbit = `HWM_SB_VCORE; end
      `HWM_R_V33:   begin m.hi = `HWM_R_V33_HI;  m.sbit = `HWM_SB_V33;   end
      `HWM_R_V5:    begin m.hi = `HWM_R_V5_HI;   m.sbit = `HWM_SB_V5;    end
      `HWM_R_V12:   begin m.hi = `HWM_R_V12_HI;  m.sbit = `HWM_SB_V12;   end
      `HWM_R_VN12:  begin m.hi = `HWM_R_VN12_HI; m.sbit = `HWM_SB_VN12;  end
      `HWM_R_VN5:   begin m.hi = `HWM_R_VN5_HI;  m.sbit = `HWM_SB_VN5;   end
      `HWM_R_TEMP1: begin
        m.hi = `HWM_R_T1_HI;
        m.sbit = `HWM_SB_T1;
        m.has_lo = 1'b0;
        m.sgn = 1'b1;
      end
      `HWM_R_FIRST_TACH: begin
        m.hi = `HWM_R_F1_LIM;
        m.sbit = `HWM_SB_FIRST_TACH;
        m.has_lo = 1'b0;
      end
      `HWM_R_SECOND_TACH: begin
        m.hi = `HWM_R_F2_LIM;
        m.sbit = `HWM_SB_SECOND_TACH;
        m.has_lo = 1'b0;
      end
      default: m.vld = 1'b0;
    endcase
    return m;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       intr_s1, intr_s2, intr_s3;
  logic [4:0] vid_s1, vid_s2;
  logic       vid4_cap;
  always_ff @(posedge ref_clk) begin
    intr_s1 <= intrusion_pin;
    intr_s2 <= intr_s1;
    intr_s3 <= intr_s2;
    vid_s1  <= voltage_ident_straps;
    vid_s2  <= vid_s1;
  end

  // Strap caught while reset is held, kept afterwards
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vid4_cap <= vid_s2[4];
    end
  end

  // ****************************************
  // Host access decode
  // ****************************************
  logic [6:0] ptr;
  logic [6:0] next_ptr;
  logic       busy;
  logic       idx_wr, dacc, dwr, drd, dflt;
  logic       in_ram;
  logic [4:0] ram_idx;
  assign idx_wr  = !host_req.sel && host_req.wr;
  assign dwr     = host_req.sel && host_req.wr;
  assign drd     = host_req.sel && host_req.rd;
  assign dacc    = dwr || drd;
  // Both 20h-3Fh and 60h-7Fh have bit 5 set
  assign in_ram  = ptr[5];
  assign ram_idx = ptr[4:0];
  assign dflt    = dwr && ptr == `HWM_IDX_CFG &&
                   host_req.wdata[`HWM_CFG_DFLT];
  always_comb begin
    next_ptr = ptr;
    if (ptr >= `HWM_IDX_ALIAS && ptr != `HWM_IDX_TOP) begin
      next_ptr = ptr + 7'h01;
    end else if (ptr == `HWM_IDX_ST1 || ptr == `HWM_IDX_MSK1) begin
      next_ptr = ptr + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ptr  <= 7'h00;
      busy <= 1'b0;
    end else if (idx_wr) begin
      ptr  <= host_req.wdata[6:0];
      busy <= 1'b1;
    end else if (dacc) begin
      ptr  <= next_ptr;
      busy <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] cfg, msk1, msk2, pinc;
  logic [3:0] fdiv;
  logic       iclr;
  // Bit 7 is never stored, so it always reads back zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst || dflt) begin
      cfg <= `HWM_CFG_RST;
    end else if (dwr && ptr == `HWM_IDX_CFG) begin
      cfg <= {1'b0, host_req.wdata[6:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || dflt) begin
      msk1 <= 8'h00;
      msk2 <= 8'h00;
    end else if (dwr && ptr == `HWM_IDX_MSK1) begin
      msk1 <= host_req.wdata;
    end else if (dwr && ptr == `HWM_IDX_MSK2) begin
      msk2 <= host_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || dflt) begin
      fdiv <= `HWM_FDIV_RST;
      pinc <= `HWM_PINC_RST;
    end else if (dwr && ptr == `HWM_IDX_FDIV) begin
      fdiv <= host_req.wdata[7:4];
    end else if (dwr && ptr == `HWM_IDX_PINC) begin
      pinc <= host_req.wdata;
    end
  end

  // Held one cycle, then drops by itself
  always_ff @(posedge ref_clk) begin
    if (sys_rst || dflt) begin
      iclr <= 1'b0;
    end else begin
      iclr <= dwr && ptr == `HWM_IDX_ICLR &&
              host_req.wdata[`HWM_ICLR_BIT];
    end
  end

  assign monitor_run = cfg[`HWM_CFG_START] && !cfg[`HWM_CFG_HALT];
  assign adc_clk_sel = pinc[5:4];
  assign {second_tach_divisor_hi, second_tach_divisor_lo,
          first_tach_divisor_hi, first_tach_divisor_lo} = fdiv;

  // ****************************************
  // Value RAM
  // ****************************************
  logic [7:0] ram [32];
  logic       vc_init;
  logic       cv;
  logic [8:0] vc_sum;
  logic [7:0] vc_hi, vc_lo;
  // Conversions are dropped in standby or halt
  assign cv     = conv.valid && monitor_run;
  assign vc_sum = {1'b0, conv.value} + {1'b0, `HWM_VC_MARGIN};
  assign vc_hi  = vc_sum[8] ? 8'hff : vc_sum[7:0];
  assign vc_lo  = (conv.value < `HWM_VC_MARGIN) ? 8'h00 :
                  conv.value - `HWM_VC_MARGIN;
  // First core reading after reset seeds its own limits
  always_ff @(posedge ref_clk) begin
    if (sys_rst || dflt) begin
      vc_init <= 1'b1;
    end else if ((cv && conv.chan == `HWM_R_VCORE) ||
                 (dwr && in_ram && (ram_idx == `HWM_R_VC_HI ||
                                    ram_idx == `HWM_R_VC_LO))) begin
      vc_init <= 1'b0;
    end
  end

  // Host write wins over a conversion to the same cell
  for (genvar i = 0; i < 32; i++) begin : g_ram
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        ram[i] <= 8'h00;
      end else if (dwr && in_ram && ram_idx == 5'(i)) begin
        ram[i] <= host_req.wdata;
      end else if (cv && conv.chan == 5'(i)) begin
        ram[i] <= conv.value;
      end else if (cv && vc_init && conv.chan == `HWM_R_VCORE &&
                   5'(i) == `HWM_R_VC_HI) begin
        ram[i] <= vc_hi;
      end else if (cv && vc_init && conv.chan == `HWM_R_VCORE &&
                   5'(i) == `HWM_R_VC_LO) begin
        ram[i] <= vc_lo;
      end
    end
  end

  // ****************************************
  // Limit compare and status
  // ****************************************
  hwm_lim_s   lm;
  logic [7:0] lim_hi, lim_lo;
  logic       over, under;
  logic [15:0] stat, st_set, st_clr;
  assign lm     = lim_map(conv.chan);
  assign lim_hi = ram[lm.hi];
  assign lim_lo = ram[lm.hi + 5'h01];
  // Strict greater-than: full-scale high limits can never trip on unsigned channels; temp 1 compares signed, so FFh there is -1
  always_comb begin
    over  = lm.sgn ? ($signed(conv.value) > $signed(lim_hi)) :
                     (conv.value > lim_hi);
    under = lm.has_lo && conv.value < lim_lo;
    st_set = 16'h0000;
    if (cv && lm.vld && (over || under) &&
        !(vc_init && conv.chan == `HWM_R_VCORE)) begin
      st_set[lm.sbit] = 1'b1;
    end
    st_set[`HWM_SB_T2]   = temp_two_over && monitor_run;
    st_set[`HWM_SB_INTR] = intr_s2 && !intr_s3;
    st_clr = 16'h0000;
    if (drd && ptr == `HWM_IDX_ST1) begin
      st_clr[7:0] = 8'hff;
    end
    if (drd && ptr == `HWM_IDX_ST2) begin
      st_clr[15:8] = 8'hff;
    end
    if (iclr) begin
      st_clr[`HWM_SB_INTR] = 1'b1;
    end
  end

  // Set wins over status-read and clear-bit clears, not over a config write with bit 7 set, the only config write that clears status
  always_ff @(posedge ref_clk) begin
    if (sys_rst || dflt) begin
      stat <= 16'h0000;
    end else begin
      stat <= ((stat & ~st_clr) | st_set) & `HWM_ST_VALID;
    end
  end

  assign mgmt_interrupt_out = cfg[`HWM_CFG_IRQEN] &&
                              !cfg[`HWM_CFG_HALT] &&
                              |(stat & ~{2'b00, msk2[5:0], msk1});

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (!host_req.sel) begin
      rd_mux = {busy, ptr};
    end else if (in_ram) begin
      rd_mux = ram[ram_idx];
    end else begin
      unique case (ptr)
        `HWM_IDX_CFG:   rd_mux = cfg;
        `HWM_IDX_ST1:   rd_mux = stat[7:0];
        `HWM_IDX_ST2:   rd_mux = stat[15:8];
        `HWM_IDX_MSK1:  rd_mux = msk1;
        `HWM_IDX_MSK2:  rd_mux = msk2;
        `HWM_IDX_ICLR:  rd_mux = {iclr, 7'h00};
        `HWM_IDX_FDIV:  rd_mux = {fdiv, vid_s2[3:0]};
        `HWM_IDX_DEVID: rd_mux = {`HWM_DEV_ID, vid4_cap};
        `HWM_IDX_PINC:  rd_mux = pinc;
        default:        rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_rdata <= 8'h00;
    end else if (host_req.rd) begin
      host_rdata <= rd_mux;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_irq_enable: assert property (
    !cfg[`HWM_CFG_IRQEN] |-> !mgmt_interrupt_out)
    else $error("interrupt without enable");
  a_halt_gates: assert property (
    cfg[`HWM_CFG_HALT] |-> !mgmt_interrupt_out && !monitor_run)
    else $error("halt did not gate");
  a_busy_set: assert property (
    idx_wr |=> busy && ptr == $past(host_req.wdata[6:0]))
    else $error("index write lost");
  a_busy_clear: assert property (
    busy && dacc && !idx_wr |=> !busy)
    else $error("busy stuck");
  a_alias_step: assert property (
    dacc && !idx_wr && ptr >= `HWM_IDX_ALIAS && ptr != `HWM_IDX_TOP
    |=> ptr == $past(ptr) + 7'h01)
    else $error("no auto increment");
  a_alias_stop: assert property (
    dacc && !idx_wr && ptr == `HWM_IDX_TOP |=> ptr == `HWM_IDX_TOP)
    else $error("pointer ran past top");
  a_dflt_load: assert property (
    dflt |=> cfg == `HWM_CFG_RST && pinc == `HWM_PINC_RST &&
             msk1 == 8'h00 && stat == 16'h0000)
    else $error("defaults not restored");
  a_iclr_self: assert property (
    iclr |=> !iclr && (!stat[`HWM_SB_INTR] || $past(st_set[`HWM_SB_INTR])))
    else $error("intrusion clear stuck");
  a_mask_all: assert property (
    msk1 == 8'hff && msk2[5:0] == 6'h3f |-> !mgmt_interrupt_out)
    else $error("masked status interrupts");
  a_cfg_keep: assert property (
    dwr && ptr == `HWM_IDX_CFG && !dflt && st_clr == 16'h0000
    |=> (stat & $past(stat)) == $past(stat))
    else $error("config write cleared status");

  c_irq: cover property (mgmt_interrupt_out);
  c_top: cover property (dacc && ptr == `HWM_IDX_TOP);
  c_intr: cover property (st_set[`HWM_SB_INTR]);

endmodule // hwm_regbank

// *** testbench/hwm_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host on the index and data ports
// ****************************************
module hwm_host_model
  import hwm_pkg::*;
(
  input  wire logic       ref_clk,
  output hwm_host_s       host_req,
  input  wire logic [7:0] host_rdata
);
  initial host_req = '0;

  // One strobe; data is read two edges later since it stands until next rd
  task automatic port_op(input logic s, input logic w, input logic [7:0] d,
                         output logic [7:0] q);
    @(negedge ref_clk);
    host_req = '{s, w, !w, d};
    @(negedge ref_clk);
    host_req = '{s, 1'b0, 1'b0, ~d};
    @(negedge ref_clk);
    q = host_rdata;
  endtask

  // Poll busy up to four times first, then write the pointer even if one is still pending
  task automatic set_index(input logic [6:0] a);
    logic [7:0] q;
    q = 8'h80;
    for (int i = 0; i < 4 && q[7] !== 1'b0; i++) begin
      port_op(1'b0, 1'b0, 8'h00, q);
    end
    port_op(1'b0, 1'b1, {1'b0, a}, q);
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    set_index(a);
    port_op(1'b1, 1'b1, d, q);
  endtask

  task automatic rd_reg(input logic [6:0] a, output logic [7:0] q);
    set_index(a);
    port_op(1'b1, 1'b0, 8'h00, q);
  endtask
endmodule // hwm_host_model

// *** testbench/test_hw_monitor_register_bank.sv ***
`timescale 1ns/1ps
`include "hwm_regs.svh"
module test_hw_monitor_register_bank
  import hwm_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  hwm_host_s  host_req;
  logic [7:0] host_rdata;
  hwm_conv_s  conv = '0;
  logic       temp_two_over = 1'b0;
  logic       intrusion_pin = 1'b0;
  logic [4:0] straps = 5'h15;
  logic       irq;
  logic       run;
  logic [1:0] adc_sel;
  logic [3:0] div;
  logic [7:0] q;
  int         failures = 0;
  int         total_checks = 0;
  int         cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  hwm_host_model hwm_host_model_inst (
    .ref_clk    (ref_clk),
    .host_req   (host_req),
    .host_rdata (host_rdata)
  );

  hwm_regbank hwm_regbank_inst (
    .ref_clk                (ref_clk),
    .sys_rst                (sys_rst),
    .host_req               (host_req),
    .host_rdata             (host_rdata),
    .conv                   (conv),
    .temp_two_over          (temp_two_over),
    .intrusion_pin          (intrusion_pin),
    .voltage_ident_straps   (straps),
    .mgmt_interrupt_out     (irq),
    .monitor_run            (run),
    .adc_clk_sel            (adc_sel),
    .first_tach_divisor_lo  (div[0]),
    .first_tach_divisor_hi  (div[1]),
    .second_tach_divisor_lo (div[2]),
    .second_tach_divisor_hi (div[3])
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t pins=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic s, input logic w, input logic [7:0] d);
    hwm_host_model_inst.port_op(s, w, d, q);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    hwm_host_model_inst.wr_reg(a, d);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    hwm_host_model_inst.rd_reg(a, q);
    chk_byte(q, e);
  endtask

  task automatic convert(input logic [4:0] ch, input logic [7:0] v);
    @(negedge ref_clk);
    conv = '{1'b1, ch, v};
    @(negedge ref_clk);
    conv = '0;
    @(negedge ref_clk);
  endtask

  task automatic lim_case(input logic [4:0] ch, input logic [6:0] hi,
                          input logic [6:0] st, input logic [7:0] e);
    wr(hi, 8'h20);
    convert(ch, 8'h30);
    rd_chk(st, e);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd_chk(`HWM_IDX_CFG, `HWM_CFG_RST);
    rd_chk(`HWM_IDX_MSK1, 8'h00);
    rd_chk(`HWM_IDX_MSK2, 8'h00);
    rd_chk(`HWM_IDX_PINC, `HWM_PINC_RST);
    rd_chk(`HWM_IDX_DEVID, {`HWM_DEV_ID, straps[4]});
    hwm_host_model_inst.rd_reg(`HWM_IDX_FDIV, q);
    chk_byte(q, {`HWM_FDIV_RST, straps[3:0]});
    chk_pin({irq, run, adc_sel}, 4'h4);
    chk_pin(div, 4'h5);
    // Index port: bit 7 of the write is dropped, busy shows until data use
    op(1'b0, 1'b1, 8'hc0);
    op(1'b0, 1'b0, 8'h00);
    chk_byte(q, 8'hc0);
    op(1'b1, 1'b0, 8'h00);
    op(1'b0, 1'b0, 8'h00);
    chk_byte(q, 8'h40);
    wr(7'h23, 8'ha5);
    rd_chk(7'h63, 8'ha5);
    wr(7'h7e, 8'h11);
    op(1'b1, 1'b1, 8'h22);
    op(1'b0, 1'b0, 8'h00);
    chk_byte(q, 8'h7f);
    rd_chk(7'h3e, 8'h11);
    rd_chk(7'h3f, 8'h22);
    wr(`HWM_IDX_ST1, 8'hff);
    rd_chk(`HWM_IDX_ST1, 8'h00);
    wr(7'h45, 8'h5a);
    rd_chk(7'h45, 8'h00);
    for (int s = 0; s < 3; s++) begin
      wr(`HWM_IDX_PINC, 8'h44 | 8'(s << 4));
      chk_pin({2'b00, adc_sel}, 4'(s));
    end
    wr(`HWM_IDX_FDIV, 8'ha0);
    chk_pin(div, 4'ha);
    lim_case(`HWM_R_V5, 7'h31, `HWM_IDX_ST1, 8'h08);
    lim_case(`HWM_R_V33, 7'h2f, `HWM_IDX_ST1, 8'h04);
    lim_case(`HWM_R_TEMP1, 7'h39, `HWM_IDX_ST1, 8'h10);
    lim_case(`HWM_R_FIRST_TACH, 7'h3b, `HWM_IDX_ST1, 8'h40);
    rd_chk(7'h28, 8'h30);
    lim_case(`HWM_R_SECOND_TACH, 7'h3c, `HWM_IDX_ST1, 8'h80);
    lim_case(`HWM_R_V12, 7'h33, `HWM_IDX_ST2, 8'h01);
    lim_case(`HWM_R_VN12, 7'h35, `HWM_IDX_ST2, 8'h02);
    lim_case(`HWM_R_VN5, 7'h37, `HWM_IDX_ST2, 8'h04);
    chk_pin({3'b000, irq}, 4'h0);
    @(negedge ref_clk) temp_two_over = 1'b1;
    @(negedge ref_clk) temp_two_over = 1'b0;
    rd_chk(`HWM_IDX_ST1, 8'h20);
    wr(7'h31, 8'hff);
    convert(`HWM_R_V5, 8'hff);
    rd_chk(`HWM_IDX_ST1, 8'h00);
    // Interrupt path: enable, mask, halt, disable
    wr(`HWM_IDX_CFG, 8'h03);
    wr(7'h31, 8'h20);
    convert(`HWM_R_V5, 8'h30);
    chk_pin({3'b000, irq}, 4'h1);
    wr(`HWM_IDX_MSK1, 8'h08);
    chk_pin({3'b000, irq}, 4'h0);
    wr(`HWM_IDX_MSK1, 8'h00);
    wr(`HWM_IDX_CFG, 8'h0b);
    chk_pin({2'b00, irq, run}, 4'h0);
    convert(`HWM_R_V33, 8'h30);
    wr(`HWM_IDX_CFG, 8'h03);
    chk_pin({2'b00, irq, run}, 4'h3);
    wr(`HWM_IDX_CFG, 8'h00);
    chk_pin({2'b00, irq, run}, 4'h0);
    rd_chk(`HWM_IDX_ST1, 8'h08);
    rd_chk(`HWM_IDX_ST1, 8'h00);
    wr(`HWM_IDX_CFG, 8'h03);
    convert(`HWM_R_V12, 8'h30);
    chk_pin({3'b000, irq}, 4'h1);
    wr(`HWM_IDX_MSK2, 8'h01);
    chk_pin({3'b000, irq}, 4'h0);
    rd_chk(`HWM_IDX_ST2, 8'h01);
    // Intrusion latch, then a second event wiped by the clear bit
    @(negedge ref_clk) intrusion_pin = 1'b1;
    rd_chk(`HWM_IDX_ST2, 8'h10);
    intrusion_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    intrusion_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    wr(`HWM_IDX_ICLR, 8'h80);
    rd_chk(`HWM_IDX_ICLR, 8'h00);
    rd_chk(`HWM_IDX_ST2, 8'h00);
    wr(`HWM_IDX_CFG, 8'h80);
    rd_chk(`HWM_IDX_CFG, `HWM_CFG_RST);
    rd_chk(`HWM_IDX_MSK2, 8'h00);
    rd_chk(`HWM_IDX_PINC, `HWM_PINC_RST);
    chk_pin(div, 4'h5);
    // Core limits seeded by the first core reading, then compared
    convert(`HWM_R_VCORE, 8'h80);
    rd_chk(7'h2b, 8'h80 + `HWM_VC_MARGIN);
    rd_chk(7'h2c, 8'h80 - `HWM_VC_MARGIN);
    rd_chk(`HWM_IDX_ST1, 8'h00);
    wr(`HWM_IDX_CFG, 8'h03);
    convert(`HWM_R_VCORE, 8'h90);
    chk_pin({3'b000, irq}, 4'h1);
    wr(`HWM_IDX_MSK1, 8'hff);
    wr(`HWM_IDX_MSK2, 8'h3f);
    chk_pin({3'b000, irq}, 4'h0);
    rd_chk(`HWM_IDX_ST1, 8'h01);
    // Full-scale high limit still lets a low violation through
    wr(7'h31, 8'hff);
    wr(7'h32, 8'h40);
    convert(`HWM_R_V5, 8'h30);
    rd_chk(`HWM_IDX_ST1, 8'h08);
    close_out();
  end
endmodule // test_hw_monitor_register_bank
